// ---- core/cbr_pkg.sv ----
package cbr_pkg;

	// instruction lengths in bytes
	localparam logic [1:0] LEN_1 = 2'h1;
	localparam logic [1:0] LEN_2 = 2'h2;
	localparam logic [1:0] LEN_3 = 2'h3;

	// execution times in core cycles
	localparam logic [3:0] CYC_1 = 4'h1;
	localparam logic [3:0] CYC_2 = 4'h2;
	localparam logic [3:0] CYC_3 = 4'h3;
	localparam logic [3:0] CYC_4 = 4'h4;

	// opcodes handled here
	localparam logic [7:0] OP_NOP = 8'h00;
	localparam logic [7:0] OP_JMP_IND = 8'h73;
	localparam logic [7:0] OP_RET = 8'h22;
	localparam logic [7:0] OP_RETI = 8'h32;
	localparam logic [4:0] OP_ACALL_LO = 5'h11;
	localparam logic [4:0] OP_AJMP_LO = 5'h01;
	localparam logic [7:0] OP_SJMP = 8'h80;
	localparam logic [7:0] OP_JC = 8'h40;
	localparam logic [7:0] OP_JNC = 8'h50;
	localparam logic [7:0] OP_JZ = 8'h60;
	localparam logic [7:0] OP_JNZ = 8'h70;
	localparam logic [4:0] OP_DJNZ_R_HI = 5'h1b;
	localparam logic [7:0] OP_LJMP = 8'h02;
	localparam logic [7:0] OP_LCALL = 8'h12;
	localparam logic [7:0] OP_JB = 8'h20;
	localparam logic [7:0] OP_JNB = 8'h30;
	localparam logic [7:0] OP_JBC = 8'h10;
	localparam logic [7:0] OP_CJNE_AI = 8'hb4;
	localparam logic [7:0] OP_CJNE_AD = 8'hb5;
	localparam logic [3:0] OP_CJNE_HI = 4'hb;
	localparam logic [7:0] OP_DJNZ_D = 8'hd5;
	localparam logic [3:0] OP_ADD_HI = 4'h2;
	localparam logic [3:0] OP_ADDC_HI = 4'h3;
	localparam logic [3:0] OP_IMM_LO = 4'h4;
	localparam logic [3:0] OP_REG_LO = 4'h8;
	localparam logic [7:0] OP_CLR_BIT = 8'hc2;
	localparam logic [7:0] OP_SETB_BIT = 8'hd2;
	localparam logic [7:0] OP_CPL_BIT = 8'hb2;
	localparam logic [7:0] OP_MOV_BIT_C = 8'h92;

	// one fetched instruction: opcode and its two following bytes
	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] op1;
		logic [7:0] op2;
	} cbr_instr_type;

	// arithmetic status flags
	typedef struct packed {
		logic carry;
		logic overflow_flag;
		logic aux_carry_flag;
	} cbr_flags_type;

	typedef enum logic [4:0] {
		K_NOP = 5'h00, K_JMPIND = 5'h01, K_ACALL = 5'h02, K_AJMP = 5'h03,
		K_SJMP = 5'h04, K_JC = 5'h05, K_JNC = 5'h06, K_JZ = 5'h07,
		K_JNZ = 5'h08, K_DJNZR = 5'h09, K_LJMP = 5'h0a, K_LCALL = 5'h0b,
		K_JB = 5'h0c, K_JNB = 5'h0d, K_JBC = 5'h0e, K_CJNE = 5'h0f,
		K_DJNZD = 5'h10, K_ADD = 5'h11, K_ADDC = 5'h12, K_RET = 5'h13,
		K_CLRB = 5'h14, K_SETB = 5'h15, K_CPLB = 5'h16, K_MOVBC = 5'h17,
		K_BAD = 5'h18
	} cbr_kind_type;

	typedef enum logic [0:0] {
		S_IDLE = 1'b0,
		S_EXEC = 1'b1
	} cbr_state_type;

endpackage : cbr_pkg

// ---- core/cbr_adder.sv ----
`timescale 1ns/100ps
`default_nettype none

// eight-bit add with carry-in, producing the three arithmetic flags
module cbr_adder
	import cbr_pkg::*;
(
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic cin,
	output logic [7:0] sum,
	output cbr_flags_type flags
);

	logic [4:0] low_sum;
	logic [3:0] mid_sum;
	logic [1:0] top_sum;

	// split at bit 3 and bit 6 so each carry is visible on its own
	assign low_sum = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
	assign mid_sum = {1'b0, a[6:4]} + {1'b0, b[6:4]} + {3'h0, low_sum[4]};
	assign top_sum = {1'b0, a[7]} + {1'b0, b[7]} + {1'b0, mid_sum[3]};
	assign sum = {top_sum[0], mid_sum[2:0], low_sum[3:0]};
	assign flags.carry = top_sum[1];
	assign flags.overflow_flag = top_sum[1] ^ mid_sum[3];
	assign flags.aux_carry_flag = low_sum[4];

endmodule : cbr_adder
`default_nettype wire

// ---- core/cbr_exec.sv ----
// Operation
// - indirect jump via accumulator plus pointer: 1 byte, 3 cycles
// - ACALL absolute call: 2 bytes, 3 cycles
// - SJMP short relative jump: 2 bytes, 3 cycles
// - JC/JNC on carry: 2 bytes, 3 cycles
// - JZ/JNZ on accumulator: 2 bytes, 3 cycles
// - DJNZ register: decrement, branch if nonzero, 2/3
// - LCALL long call: 3 bytes, 4 cycles
// - JB/JNB on direct bit: 3 bytes, 4 cycles
// - JBC: branch if bit set, clear it; 3/4
// - all CJNE forms: compare, branch if unequal; 3/4
// - DJNZ direct byte: decrement, branch if nonzero; 3/4
// - plain port input reads the pin level
// - read-modify-write on a port reads the latch
// - fixed set of read-modify-write instructions
// - port bit ops rewrite whole latch byte
// - ADD sums source and accumulator, ignoring carry
// - ADDC adds source, carry and accumulator
// - carry flag from carry out of bit 7
// - overflow flag from carries out of bits 6, 7
// - aux carry flag from carry out of bit 3
`timescale 1ns/100ps
`default_nettype none

module cbr_exec
	import cbr_pkg::*;
#(
	parameter int PC_WIDTH = 16
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire cbr_instr_type instr,
	input wire logic [PC_WIDTH-1:0] pc_in,
	input wire logic [7:0] acc_in,
	input wire logic carry_in,
	input wire logic [15:0] data_pointer,
	input wire logic [PC_WIDTH-1:0] stack_pc,
	input wire logic [7:0] src_byte,
	input wire logic src_is_port,
	input wire logic [2:0] bit_sel,
	input wire logic [7:0] port_latch,
	input wire logic [7:0] port_pin,
	output logic busy_q,
	output logic done_q,
	output logic bad_op_q,
	output logic taken_q,
	output logic [PC_WIDTH-1:0] pc_q,
	output logic [1:0] len_q,
	output logic acc_we_q,
	output logic [7:0] acc_q,
	output cbr_flags_type flags_we_q,
	output cbr_flags_type flags_q,
	output logic wb_en_q,
	output logic wb_port_q,
	output logic [7:0] wb_data_q,
	output logic push_q,
	output logic [PC_WIDTH-1:0] ret_pc_q
);

	// signed relative target from the address after the branch
	function automatic logic [PC_WIDTH-1:0] rel_target(
		input logic [PC_WIDTH-1:0] base,
		input logic [7:0] off
	);
		rel_target = base + {{(PC_WIDTH-8){off[7]}}, off};
	endfunction : rel_target

	// replace one bit of a byte, keeping the other seven
	function automatic logic [7:0] put_bit(
		input logic [7:0] value,
		input logic [2:0] pos,
		input logic b
	);
		logic [7:0] mask;
		mask = 8'h01 << pos;
		put_bit = b ? (value | mask) : (value & ~mask);
	endfunction : put_bit

	cbr_state_type state_q;
	cbr_state_type state_d;
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic [7:0] pin_meta_q;
	logic [7:0] pin_sync_q;

	// port pins are asynchronous to the core, so pass two stages first
	always_ff @(posedge clk) begin
		pin_meta_q <= port_pin;
		pin_sync_q <= pin_meta_q;
	end

	// decode: kind, length and cycle count
	logic [7:0] opc;
	cbr_kind_type kind;
	logic [1:0] len;
	logic [3:0] cyc;

	assign opc = instr.opcode;

	always_comb begin
		kind = K_BAD;
		len = LEN_1;
		cyc = CYC_1;
		if (opc == OP_NOP) begin
			kind = K_NOP;
		end else if (opc == OP_JMP_IND) begin
			kind = K_JMPIND;
			cyc = CYC_3;
		end else if (opc == OP_RET || opc == OP_RETI) begin
			kind = K_RET;
			cyc = CYC_4;
		end else if (opc[4:0] == OP_ACALL_LO) begin
			kind = K_ACALL;
			len = LEN_2;
			cyc = CYC_3;
		end else if (opc[4:0] == OP_AJMP_LO) begin
			kind = K_AJMP;
			len = LEN_2;
			cyc = CYC_3;
		end else if (opc == OP_SJMP || opc == OP_JC || opc == OP_JNC ||
				opc == OP_JZ || opc == OP_JNZ || opc[7:3] == OP_DJNZ_R_HI) begin
			len = LEN_2;
			cyc = CYC_3;
			case (opc)
				OP_SJMP: kind = K_SJMP;
				OP_JC: kind = K_JC;
				OP_JNC: kind = K_JNC;
				OP_JZ: kind = K_JZ;
				OP_JNZ: kind = K_JNZ;
				default: kind = K_DJNZR;
			endcase
		end else if (opc == OP_LJMP || opc == OP_LCALL || opc == OP_JB ||
				opc == OP_JNB || opc == OP_JBC || opc == OP_DJNZ_D ||
				(opc[7:4] == OP_CJNE_HI && opc[3:2] != 2'h0)) begin
			len = LEN_3;
			cyc = CYC_4;
			case (opc)
				OP_LJMP: kind = K_LJMP;
				OP_LCALL: kind = K_LCALL;
				OP_JB: kind = K_JB;
				OP_JNB: kind = K_JNB;
				OP_JBC: kind = K_JBC;
				OP_DJNZ_D: kind = K_DJNZD;
				default: kind = K_CJNE;
			endcase
		end else if (opc[7:4] == OP_ADD_HI || opc[7:4] == OP_ADDC_HI) begin
			if (opc[3:0] >= OP_IMM_LO) begin
				kind = (opc[7:4] == OP_ADD_HI) ? K_ADD : K_ADDC;
				len = (opc[3:0] == OP_IMM_LO || opc[3:0] == OP_IMM_LO + 4'h1) ? LEN_2 : LEN_1;
				cyc = (opc[3:0] >= OP_REG_LO) ? CYC_1 : CYC_2;
			end
		end else if (opc == OP_CLR_BIT || opc == OP_SETB_BIT ||
				opc == OP_CPL_BIT || opc == OP_MOV_BIT_C) begin
			len = LEN_2;
			cyc = CYC_2;
			case (opc)
				OP_CLR_BIT: kind = K_CLRB;
				OP_SETB_BIT: kind = K_SETB;
				OP_CPL_BIT: kind = K_CPLB;
				default: kind = K_MOVBC;
			endcase
		end
	end

	// operand source: src_byte off-port; on a port, latch for the modify-and-rewrite group, synchronised pin otherwise
	logic rmw;
	logic [7:0] opnd;
	logic bit_val;

	assign rmw = (kind == K_JBC) || (kind == K_DJNZD) || (kind == K_DJNZR) ||
		(kind == K_CLRB) || (kind == K_SETB) || (kind == K_CPLB) ||
		(kind == K_MOVBC);
	assign opnd = !src_is_port ? src_byte :
		(rmw ? port_latch : pin_sync_q);
	assign bit_val = opnd[bit_sel];

	// addresses
	logic [PC_WIDTH-1:0] pc_seq;
	logic [PC_WIDTH-1:0] rel_short;
	logic [PC_WIDTH-1:0] rel_long;
	logic [PC_WIDTH-1:0] abs11;
	logic [PC_WIDTH-1:0] ind_tgt;

	assign pc_seq = pc_in + {{(PC_WIDTH-2){1'b0}}, len};
	assign rel_short = rel_target(pc_seq, instr.op1);
	assign rel_long = rel_target(pc_seq, instr.op2);
	assign abs11 = {pc_seq[PC_WIDTH-1:11], opc[7:5], instr.op1};
	assign ind_tgt = PC_WIDTH'(data_pointer + {8'h00, acc_in});

	// compare, decrement and add
	logic [7:0] cmp_dst;
	logic [7:0] cmp_src;
	logic [7:0] dec_val;
	logic [7:0] add_b;
	logic [7:0] add_sum;
	cbr_flags_type add_flags;

	assign cmp_dst = (opc == OP_CJNE_AI || opc == OP_CJNE_AD) ? acc_in : opnd;
	assign cmp_src = (opc == OP_CJNE_AD) ? opnd : instr.op1;
	assign dec_val = opnd - 8'h01;
	assign add_b = (opc[3:0] == OP_IMM_LO) ? instr.op1 : opnd;

	cbr_adder u_adder (
		.a(acc_in),
		.b(add_b),
		.cin((kind == K_ADDC) ? carry_in : 1'b0),
		.sum(add_sum),
		.flags(add_flags)
	);

	// branch decision and next address
	logic take;
	logic [PC_WIDTH-1:0] next_pc;

	always_comb begin
		take = 1'b0;
		next_pc = pc_seq;
		case (kind)
			K_JMPIND: take = 1'b1;
			K_RET: take = 1'b1;
			K_ACALL, K_AJMP: take = 1'b1;
			K_LJMP, K_LCALL: take = 1'b1;
			K_SJMP: take = 1'b1;
			K_JC: take = carry_in;
			K_JNC: take = !carry_in;
			K_JZ: take = (acc_in == 8'h00);
			K_JNZ: take = (acc_in != 8'h00);
			K_DJNZR, K_DJNZD: take = (dec_val != 8'h00);
			K_JB, K_JBC: take = bit_val;
			K_JNB: take = !bit_val;
			K_CJNE: take = (cmp_dst != cmp_src);
			default: take = 1'b0;
		endcase
		case (kind)
			K_JMPIND: next_pc = ind_tgt;
			K_RET: next_pc = stack_pc;
			K_ACALL, K_AJMP: next_pc = abs11;
			K_LJMP, K_LCALL: next_pc = {instr.op1, instr.op2};
			K_SJMP, K_JC, K_JNC, K_JZ, K_JNZ, K_DJNZR: next_pc = take ? rel_short : pc_seq;
			K_JB, K_JNB, K_JBC, K_CJNE, K_DJNZD: next_pc = take ? rel_long : pc_seq;
			default: next_pc = pc_seq;
		endcase
	end

	// write-back byte: a port bit op rewrites all eight latch bits
	logic wb_en;
	logic [7:0] wb_data;

	always_comb begin
		wb_en = 1'b1;
		wb_data = opnd;
		case (kind)
			K_DJNZR, K_DJNZD: wb_data = dec_val;
			K_JBC: begin
				wb_en = bit_val;
				wb_data = put_bit(opnd, bit_sel, 1'b0);
			end
			K_CLRB: wb_data = put_bit(opnd, bit_sel, 1'b0);
			K_SETB: wb_data = put_bit(opnd, bit_sel, 1'b1);
			K_CPLB: wb_data = put_bit(opnd, bit_sel, !bit_val);
			K_MOVBC: wb_data = put_bit(opnd, bit_sel, carry_in);
			default: wb_en = 1'b0;
		endcase
	end

	// sequencer: count out the cycle figure of the instruction
	logic accept;
	logic last;

	assign accept = (state_q == S_IDLE) && start;
	assign last = (state_q == S_EXEC) && (cnt_q == 4'h0);

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		case (state_q)
			S_IDLE: begin
				if (start) begin
					state_d = S_EXEC;
					cnt_d = cyc - 4'h1;
				end
			end
			S_EXEC: begin
				if (cnt_q == 4'h0) begin
					state_d = S_IDLE;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			default: state_d = S_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= S_IDLE;
			cnt_q <= 4'h0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			busy_q <= (state_d == S_EXEC);
			done_q <= last;
		end
	end

	// results are captured at acceptance and held until the next one
	always_ff @(posedge clk) begin
		if (rst) begin
			bad_op_q <= 1'b0;
			taken_q <= 1'b0;
			pc_q <= '0;
			len_q <= LEN_1;
			acc_we_q <= 1'b0;
			acc_q <= 8'h00;
			flags_we_q <= '0;
			flags_q <= '0;
			wb_en_q <= 1'b0;
			wb_port_q <= 1'b0;
			wb_data_q <= 8'h00;
			push_q <= 1'b0;
			ret_pc_q <= '0;
		end else if (accept) begin
			bad_op_q <= (kind == K_BAD);
			taken_q <= take;
			pc_q <= next_pc;
			len_q <= len;
			acc_we_q <= (kind == K_ADD) || (kind == K_ADDC);
			acc_q <= add_sum;
			flags_we_q.carry <= (kind == K_ADD) || (kind == K_ADDC) || (kind == K_CJNE);
			flags_we_q.overflow_flag <= (kind == K_ADD) || (kind == K_ADDC);
			flags_we_q.aux_carry_flag <= (kind == K_ADD) || (kind == K_ADDC);
			flags_q.carry <= (kind == K_CJNE) ? (cmp_src > cmp_dst) : add_flags.carry;
			flags_q.overflow_flag <= add_flags.overflow_flag;
			flags_q.aux_carry_flag <= add_flags.aux_carry_flag;
			wb_en_q <= wb_en;
			wb_port_q <= src_is_port && wb_en;
			wb_data_q <= wb_data;
			push_q <= (kind == K_ACALL) || (kind == K_LCALL);
			ret_pc_q <= pc_seq;
		end
	end

endmodule : cbr_exec
`default_nettype wire

// ---- bench/cbr_exec_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none

module cbr_exec_monitor
	import cbr_pkg::*;
#(
	parameter int PC_WIDTH = 16
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire cbr_instr_type instr,
	input wire logic [PC_WIDTH-1:0] pc_in,
	input wire logic [7:0] acc_in,
	input wire logic carry_in,
	input wire logic [15:0] data_pointer,
	input wire logic src_is_port,
	input wire logic [2:0] bit_sel,
	input wire logic [7:0] port_latch,
	input wire logic busy_q,
	input wire logic done_q,
	input wire logic taken_q,
	input wire logic [PC_WIDTH-1:0] pc_q,
	input wire logic [7:0] acc_q,
	input wire cbr_flags_type flags_q,
	input wire logic wb_port_q,
	input wire logic [7:0] wb_data_q,
	input wire logic push_q,
	input wire logic [PC_WIDTH-1:0] ret_pc_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// reference values formed from the inputs at the accept edge
	wire logic take = start && !busy_q;
	wire logic [7:0] opc = instr.opcode;
	wire logic add_i = opc[3:0] == OP_IMM_LO && (opc[7:4] == OP_ADD_HI || opc[7:4] == OP_ADDC_HI);
	wire logic cin = opc[7:4] == OP_ADDC_HI && carry_in; // plain add ignores carry
	wire logic [8:0] s9 = {1'b0, acc_in} + {1'b0, instr.op1} + 9'(cin);
	wire logic [7:0] s7 = {1'b0, acc_in[6:0]} + {1'b0, instr.op1[6:0]} + 8'(cin);
	wire logic [4:0] s4 = {1'b0, acc_in[3:0]} + {1'b0, instr.op1[3:0]} + 5'(cin);
	wire logic ov = s7[7] ^ s9[8];
	wire logic ac = s4[4];
	wire logic [PC_WIDTH-1:0] nx2 = pc_in + PC_WIDTH'(2);
	wire logic [PC_WIDTH-1:0] rel2 = nx2 + PC_WIDTH'(signed'(instr.op1));
	wire logic [PC_WIDTH-1:0] nx3 = pc_in + PC_WIDTH'(3);
	wire logic [PC_WIDTH-1:0] lt = PC_WIDTH'({instr.op1, instr.op2});
	wire logic [PC_WIDTH-1:0] ind = PC_WIDTH'(acc_in) + PC_WIDTH'(data_pointer);
	wire logic [7:0] set_v = port_latch | (8'h01 << bit_sel);

	sjmp_time_a: assert property (take && opc == OP_SJMP |=> busy_q [*3] ##1 done_q)
		else $error("short jump timing wrong");
	lcall_time_a: assert property (take && opc == OP_LCALL |=> busy_q [*4] ##1 done_q)
		else $error("long call timing wrong");
	lcall_push_a: assert property (take && opc == OP_LCALL |=> push_q && ret_pc_q == $past(nx3) && pc_q == $past(lt))
		else $error("long call target or return wrong");
	jmp_ind_a: assert property (take && opc == OP_JMP_IND |=> pc_q == $past(ind) && taken_q)
		else $error("indirect jump target wrong");
	rel_tgt_a: assert property (take && opc == OP_SJMP |=> taken_q && pc_q == $past(rel2))
		else $error("relative target wrong");
	jc_clear_a: assert property (take && opc == OP_JC && !carry_in |=> !taken_q && pc_q == $past(nx2))
		else $error("jump on carry taken wrongly");
	add_sum_a: assert property (take && add_i |=> {flags_q.carry, acc_q} == $past(s9))
		else $error("add sum or carry wrong");
	ovf_flag_a: assert property (take && add_i |=> flags_q.overflow_flag == $past(ov))
		else $error("overflow flag wrong");
	aux_flag_a: assert property (take && add_i |=> flags_q.aux_carry_flag == $past(ac))
		else $error("aux carry flag wrong");
	setb_port_a: assert property (take && opc == OP_SETB_BIT && src_is_port |=> wb_port_q && wb_data_q == $past(set_v))
		else $error("port bit set write-back wrong");

	// main scenarios reached
	cover property (take && opc == OP_JBC);
	cover property (take && opc == OP_CJNE_AD);
	cover property (take && opc == OP_DJNZ_D && src_is_port);
endmodule : cbr_exec_monitor

bind cbr_exec cbr_exec_monitor #(.PC_WIDTH(PC_WIDTH)) u_mon (.clk, .rst, .start, .instr, .pc_in,
	.acc_in, .carry_in, .data_pointer, .src_is_port, .bit_sel, .port_latch, .busy_q, .done_q,
	.taken_q, .pc_q, .acc_q, .flags_q, .wb_port_q, .wb_data_q, .push_q, .ret_pc_q);

`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none

module testbench
	import cbr_pkg::*;
();
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0, carry_in = 1'b0, src_is_port = 1'b0;
	cbr_instr_type instr = '0;
	logic [15:0] pc_in = '0, data_pointer = '0, stack_pc = '0;
	logic [7:0] acc_in = '0, src_byte = '0, port_latch = '0, port_pin = '0;
	logic [2:0] bit_sel = '0;
	logic busy_q, done_q, bad_op_q, taken_q, acc_we_q, push_q, wb_en_q, wb_port_q;
	logic [15:0] pc_q, ret_pc_q;
	logic [1:0] len_q;
	logic [7:0] acc_q, wb_data_q;
	cbr_flags_type flags_we_q, flags_q;
	int error_cnt = 0, checks_done = 0;

	// 100 ns period
	always #50 clk = ~clk;

	cbr_exec #(.PC_WIDTH(16)) u_dut (.clk, .rst, .start, .instr, .pc_in, .acc_in, .carry_in,
		.data_pointer, .stack_pc, .src_byte, .src_is_port, .bit_sel, .port_latch, .port_pin,
		.busy_q, .done_q, .bad_op_q, .taken_q, .pc_q, .len_q, .acc_we_q, .acc_q, .flags_we_q,
		.flags_q, .wb_en_q, .wb_port_q, .wb_data_q, .push_q, .ret_pc_q);

	task automatic report_and_stop();
		$display("errors %0d, checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : report_and_stop

	task automatic ck(input logic [15:0] g, input logic [15:0] e);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value at %0t: got %h exp %h", $time, g, e);
		end
	endtask : ck

	// one instruction: waits for the pin sampler, counts edges to done, checks length and next pc
	task automatic go(input logic [7:0] o, a, b, input logic [3:0] n, input logic [1:0] l,
		input logic [15:0] p);
		logic [3:0] c;
		repeat (3) @(posedge clk);
		start <= 1'b1;
		instr <= {o, a, b};
		@(posedge clk);
		start <= 1'b0;
		c = 4'h0;
		do begin
			@(posedge clk);
			c++;
			#1;
		end while (done_q !== 1'b1 && c < 4'hf);
		ck(16'(c), 16'(n));
		ck(16'(len_q), 16'(l));
		ck(pc_q, p);
		// hand back on an edge so callers drive inputs there; results hold until next accept
		@(posedge clk);
	endtask : go

	task automatic t_jmp();
		@(posedge clk);
		acc_in <= 8'h10;
		data_pointer <= 16'h1ff0;
		go(OP_JMP_IND, 8'h00, 8'h00, 4'h3, 2'h1, 16'h2000);
	endtask : t_jmp

	// backward offset lands on the branch itself; calls push the next address
	task automatic t_calls();
		@(posedge clk);
		pc_in <= 16'h0100;
		go(OP_SJMP, 8'hfe, 8'h00, 4'h3, 2'h2, 16'h0100);
		pc_in <= 16'h1234;
		go(8'h51, 8'h56, 8'h00, 4'h3, 2'h2, 16'h1256);
		ck(ret_pc_q, 16'h1236);
		ck(16'(push_q), 16'h0001);
		go(OP_LCALL, 8'hab, 8'hcd, 4'h4, 2'h3, 16'habcd);
		ck(ret_pc_q, 16'h1237);
		// plain jumps and returns keep the branch timing but never push
		go(8'h01, 8'h56, 8'h00, 4'h3, 2'h2, 16'h1056);
		go(OP_LJMP, 8'h43, 8'h21, 4'h4, 2'h3, 16'h4321);
		ck(16'(push_q), 16'h0000);
		stack_pc <= 16'h0abc;
		go(OP_RET, 8'h00, 8'h00, 4'h4, 2'h1, 16'h0abc);
		go(OP_RETI, 8'h00, 8'h00, 4'h4, 2'h1, 16'h0abc);
	endtask : t_calls

	task automatic t_cond();
		@(posedge clk);
		pc_in <= 16'h0200;
		carry_in <= 1'b0;
		acc_in <= 8'h00;
		go(OP_JC, 8'h10, 8'h00, 4'h3, 2'h2, 16'h0202);
		go(OP_JNC, 8'h10, 8'h00, 4'h3, 2'h2, 16'h0212);
		go(OP_JZ, 8'h10, 8'h00, 4'h3, 2'h2, 16'h0212);
		go(OP_JNZ, 8'h10, 8'h00, 4'h3, 2'h2, 16'h0202);
	endtask : t_cond

	// latch and pin disagree so the source of each read shows in the outcome
	task automatic t_djnz();
		@(posedge clk);
		pc_in <= 16'h0300;
		src_byte <= 8'h05;
		go(8'hdb, 8'h20, 8'h00, 4'h3, 2'h2, 16'h0322);
		ck(16'(wb_data_q), 16'h0004);
		src_is_port <= 1'b1;
		port_latch <= 8'h01;
		port_pin <= 8'h07;
		go(OP_DJNZ_D, 8'h80, 8'h20, 4'h4, 2'h3, 16'h0303);
		ck(16'({wb_port_q, wb_data_q}), 16'h0100);
	endtask : t_djnz

	task automatic t_bitbr();
		@(posedge clk);
		pc_in <= 16'h0400;
		bit_sel <= 3'h3;
		port_latch <= 8'h00;
		port_pin <= 8'h08;
		go(OP_JB, 8'h80, 8'h10, 4'h4, 2'h3, 16'h0413);
		go(OP_JNB, 8'h80, 8'h10, 4'h4, 2'h3, 16'h0403);
		port_latch <= 8'h0c;
		port_pin <= 8'h00;
		go(OP_JBC, 8'h80, 8'h10, 4'h4, 2'h3, 16'h0413);
		ck(16'({wb_en_q, wb_port_q, wb_data_q}), 16'h0304);
		// bit already clear: no branch and nothing written back
		port_latch <= 8'h04;
		go(OP_JBC, 8'h80, 8'h10, 4'h4, 2'h3, 16'h0403);
		ck(16'({wb_en_q, wb_port_q}), 16'h0000);
	endtask : t_bitbr

	task automatic t_cjne();
		@(posedge clk);
		pc_in <= 16'h0500;
		src_is_port <= 1'b0;
		acc_in <= 8'h05;
		src_byte <= 8'h06;
		go(OP_CJNE_AI, 8'h05, 8'h10, 4'h4, 2'h3, 16'h0503);
		go(OP_CJNE_AD, 8'h30, 8'h10, 4'h4, 2'h3, 16'h0513);
		go(8'hb8, 8'h06, 8'h10, 4'h4, 2'h3, 16'h0503);
		go(8'hb6, 8'h07, 8'h10, 4'h4, 2'h3, 16'h0513);
		ck(16'({acc_we_q, flags_we_q, flags_q.carry}), 16'h0009);
	endtask : t_cjne

	// incoming carry set: only the carrying add may use it
	task automatic t_add();
		@(posedge clk);
		pc_in <= 16'h0600;
		carry_in <= 1'b1;
		acc_in <= 8'h7f;
		go(8'h24, 8'h01, 8'h00, 4'h2, 2'h2, 16'h0602);
		ck(16'({acc_q, flags_q}), 16'h0403);
		ck(16'({acc_we_q, flags_we_q}), 16'h000f);
		acc_in <= 8'hff;
		go(8'h34, 8'h00, 8'h00, 4'h2, 2'h2, 16'h0602);
		ck(16'({acc_q, flags_q}), 16'h0005);
		acc_in <= 8'h80;
		go(8'h24, 8'h80, 8'h00, 4'h2, 2'h2, 16'h0602);
		ck(16'({acc_q, flags_q}), 16'h0006);
		src_byte <= 8'h06;
		go(8'h28, 8'h00, 8'h00, 4'h1, 2'h1, 16'h0601);
		ck(16'({acc_q, flags_q}), 16'h0430);
	endtask : t_add

	task automatic t_bitop();
		@(posedge clk);
		pc_in <= 16'h0700;
		src_is_port <= 1'b1;
		port_latch <= 8'h0f;
		bit_sel <= 3'h5;
		go(OP_SETB_BIT, 8'h80, 8'h00, 4'h2, 2'h2, 16'h0702);
		ck(16'({wb_port_q, wb_data_q}), 16'h012f);
		bit_sel <= 3'h0;
		go(OP_CLR_BIT, 8'h80, 8'h00, 4'h2, 2'h2, 16'h0702);
		ck(16'({wb_port_q, wb_data_q}), 16'h010e);
		bit_sel <= 3'h7;
		go(OP_MOV_BIT_C, 8'h80, 8'h00, 4'h2, 2'h2, 16'h0702);
		ck(16'({wb_port_q, wb_data_q}), 16'h018f);
		bit_sel <= 3'h1;
		go(OP_CPL_BIT, 8'h80, 8'h00, 4'h2, 2'h2, 16'h0702);
		ck(16'({wb_port_q, wb_data_q}), 16'h010d);
	endtask : t_bitop

	// reset while the core is idle clears every result except len_q, which returns to one byte; the core then takes work at once
	task automatic t_reset();
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		#1;
		ck(16'({busy_q, done_q, bad_op_q, taken_q, acc_we_q, push_q, wb_en_q, wb_port_q}), 16'h0000);
		ck(16'({len_q, acc_q, flags_we_q, flags_q}), 16'h4000);
		ck(pc_q, 16'h0000);
		ck(ret_pc_q | 16'(wb_data_q), 16'h0000);
		go(OP_NOP, 8'h00, 8'h00, 4'h1, 2'h1, 16'h0701);
		ck(16'(bad_op_q), 16'h0000);
		go(8'ha5, 8'h00, 8'h00, 4'h1, 2'h1, 16'h0701);
		ck(16'(bad_op_q), 16'h0001);
	endtask : t_reset

	// main sequence
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_jmp();
		t_calls();
		t_cond();
		t_djnz();
		t_bitbr();
		t_cjne();
		t_add();
		t_bitop();
		t_reset();
		report_and_stop();
	end

	// about 30 instructions of under 12 cycles each; a wide margin
	initial begin
		repeat (2000) @(posedge clk);
		error_cnt++;
		report_and_stop();
	end
endmodule : testbench

`default_nettype wire
